// >>> src/dcssi_pkg.sv
// Constants, timing counts and carrier types of the dual-channel safe stop input
`default_nettype none
package dcssi_pkg;
    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned NS_PER_MS      = 1000000;
    localparam int unsigned CLKS_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
    // Test pulse filter: dark periods below this are ignored
    localparam int unsigned TEST_PULSE_MS  = 1;
    localparam int unsigned FILTER_CYCLES  = (TEST_PULSE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Input structure
    localparam int unsigned MAX_UNITS      = 8;
    localparam int unsigned DI_COUNT       = 8;
    localparam int unsigned SRC_W          = 3;
    localparam int unsigned MS_W           = 16;
    localparam int unsigned UNITS_W        = 4;
    // Selection polarity: low selects, high deselects
    localparam logic        SEL_LEVEL      = 1'b0;
    // Response time multipliers of the monitoring cycle, and added terms in ms
    localparam int unsigned STO_MAX_MULT   = 4;
    localparam int unsigned SBC_MAX_MULT   = 8;
    localparam int unsigned SS1_EXTRA_MS   = 2;
    localparam int unsigned BUS_TERM_DEF_MS = 1;
    // Reset values
    localparam logic [MS_W-1:0] TIMER_RESET = 16'h0000;

    typedef enum logic [1:0] {
        DCSSI_RUN  = 2'b00,
        DCSSI_RAMP = 2'b01,
        DCSSI_STO  = 2'b10
    } dcssi_stop_e;

    typedef struct packed {
        logic [MS_W-1:0]    cu_changeover_tolerance;
        logic [MS_W-1:0]    mm_changeover_tolerance;
        logic [MS_W-1:0]    ss1_delay_ms;
        logic [MS_W-1:0]    safety_monitor_cycle;
        logic [MS_W-1:0]    io_sampling_time;
        logic [MS_W-1:0]    safety_bus_cycle;
        logic               isochronous_master;
        logic               sbc_enable;
        logic [UNITS_W-1:0] parallel_unit_count;
    } dcssi_cfg_s;

    typedef struct packed {
        logic            safe_torque_off;
        logic            pulses_enabled;
        logic            fast_stop_ramp;
        logic            brake_release;
        logic            cu_discrepancy_fault;
        logic            mm_discrepancy_fault;
        logic            stop_f;
        logic [MS_W-1:0] sto_worst_ms;
        logic [MS_W-1:0] bus_cycle_term;
    } dcssi_status_s;
endpackage
`default_nettype wire

// >>> src/dcssi_input_filter.sv
// Test pulse filter for one safe stop selection input
`default_nettype none
module dcssi_input_filter #(
    parameter int unsigned CYCLES = dcssi_pkg::FILTER_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic raw,
    output logic      filt_q
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] low_cnt_q;

    // Length of the current dark period, saturating
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            low_cnt_q <= '0;
        else if (ce)
        begin
            if (raw)
                low_cnt_q <= '0;
            else if (low_cnt_q != CW'(CYCLES))
                low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    // Low passes only after a full filter time; high passes at once
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            filt_q <= 1'b1;
        else if (ce)
        begin
            if (raw)
                filt_q <= 1'b1;
            else if (low_cnt_q == CW'(CYCLES - 1))
                filt_q <= 1'b0;
        end
    end

    short_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(filt_q) |-> ($past(low_cnt_q) == CW'(CYCLES - 1)) && !$past(raw))
        else $error("Selection passed before the filter time");
endmodule
`default_nettype wire

// >>> src/dcssi_safe_stop.sv
// Dual-channel selection, discrepancy check and stop sequencing for one drive
`default_nettype none
module dcssi_safe_stop #(
    parameter int unsigned CLKS_PER_MS   = dcssi_pkg::CLKS_PER_MS,
    parameter int unsigned FILTER_CYCLES = dcssi_pkg::FILTER_CYCLES
) (
    input  wire logic                                                    sys_clk,
    input  wire logic                                                    rst,
    input  wire logic                                                    ce,
    input  wire logic [dcssi_pkg::DI_COUNT-1:0]                          di,
    input  wire logic [dcssi_pkg::MAX_UNITS-1:0][dcssi_pkg::SRC_W-1:0]   first_path_source,
    input  wire logic                                                    pulse_enable_terminal,
    input  wire logic                                                    bus_select_n,
    input  wire logic                                                    fault_ack,
    input  wire dcssi_pkg::dcssi_cfg_s                                   cfg,
    output dcssi_pkg::dcssi_status_s                                     status
);
    localparam int unsigned TW = $clog2(CLKS_PER_MS + 1);

    // AND of the first-path sources of the active parallel units
    function automatic logic first_path_and(
        input logic [dcssi_pkg::DI_COUNT-1:0]                        in_di,
        input logic [dcssi_pkg::MAX_UNITS-1:0][dcssi_pkg::SRC_W-1:0] src,
        input logic [dcssi_pkg::UNITS_W-1:0]                         units
    );
        logic r;
        r = 1'b1;
        for (int i = 0; i < dcssi_pkg::MAX_UNITS; i++)
        begin
            if ((i == 0) || (dcssi_pkg::UNITS_W'(i) < units))
                r = r & in_di[src[i]];
        end
        return r;
    endfunction

    // Discrepancy counter has reached a tolerance
    function automatic logic tol_expired(
        input logic [dcssi_pkg::MS_W-1:0] cnt,
        input logic [dcssi_pkg::MS_W-1:0] tol
    );
        return cnt >= tol;
    endfunction

    // Bus term of the worst-case response: bus cycle or default
    function automatic logic [dcssi_pkg::MS_W-1:0] bus_term(
        input logic                       iso,
        input logic [dcssi_pkg::MS_W-1:0] cyc
    );
        return iso ? cyc : dcssi_pkg::MS_W'(dcssi_pkg::BUS_TERM_DEF_MS);
    endfunction

    logic                           cu_raw;
    logic                           cu_filt;
    logic                           mm_filt;
    logic                           selected;
    logic                           disagree;
    logic [TW-1:0]                  tick_cnt_q;
    logic                           ms_tick;
    logic [dcssi_pkg::MS_W-1:0]     disc_cnt_q;
    logic [dcssi_pkg::MS_W-1:0]     ramp_cnt_q;
    logic                           cu_fault_q;
    logic                           mm_fault_q;
    logic                           sto_q;
    logic                           ramp_q;
    logic                           brake_release_q;
    logic [dcssi_pkg::MS_W-1:0]     sto_worst_q;
    logic [dcssi_pkg::MS_W-1:0]     bus_term_q;
    dcssi_pkg::dcssi_stop_e         state_q;
    dcssi_pkg::dcssi_stop_e         state_d;

    // First path: chosen inputs, ANDed over the parallel units
    assign cu_raw = first_path_and(di, first_path_source, cfg.parallel_unit_count);

    // Both channels pass a test pulse filter
    dcssi_input_filter #(
        .CYCLES (FILTER_CYCLES)
    ) u_cu_filter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .raw     (cu_raw),
        .filt_q  (cu_filt)
    );

    dcssi_input_filter #(
        .CYCLES (FILTER_CYCLES)
    ) u_mm_filter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .raw     (pulse_enable_terminal),
        .filt_q  (mm_filt)
    );

    // Either channel selects on its own; the bus path acts in the stop sequence
    assign selected = (cu_filt == dcssi_pkg::SEL_LEVEL) || (mm_filt == dcssi_pkg::SEL_LEVEL);
    assign disagree = cu_filt != mm_filt;

    // Millisecond time base
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            tick_cnt_q <= '0;
        else if (ce)
            tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + 1'b1;
    end

    assign ms_tick = tick_cnt_q == TW'(CLKS_PER_MS - 1);

    // Discrepancy timer from the first edge until both channels agree
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            disc_cnt_q <= dcssi_pkg::TIMER_RESET;
        else if (ce)
        begin
            if (!disagree)
                disc_cnt_q <= dcssi_pkg::TIMER_RESET;
            else if (ms_tick && (disc_cnt_q != '1))
                disc_cnt_q <= disc_cnt_q + 1'b1;
        end
    end

    // Sticky discrepancy faults per unit; a new expiry wins over the ack
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cu_fault_q <= 1'b0;
            mm_fault_q <= 1'b0;
        end
        else if (ce)
        begin
            if (disagree && tol_expired(disc_cnt_q, cfg.cu_changeover_tolerance))
                cu_fault_q <= 1'b1;
            else if (fault_ack && !disagree)
                cu_fault_q <= 1'b0;
            if (disagree && tol_expired(disc_cnt_q, cfg.mm_changeover_tolerance))
                mm_fault_q <= 1'b1;
            else if (fault_ack && !disagree)
                mm_fault_q <= 1'b0;
        end
    end

    // Stop sequence: ramp with delay, or torque off directly
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            dcssi_pkg::DCSSI_RUN:
            begin
                if (!bus_select_n)
                    state_d = dcssi_pkg::DCSSI_STO;
                else if (selected && (cfg.ss1_delay_ms != '0))
                    state_d = dcssi_pkg::DCSSI_RAMP;
                else if (selected)
                    state_d = dcssi_pkg::DCSSI_STO;
            end
            dcssi_pkg::DCSSI_RAMP:
            begin
                if (!bus_select_n || (ms_tick && (ramp_cnt_q <= 16'h0001)))
                    state_d = dcssi_pkg::DCSSI_STO;
            end
            dcssi_pkg::DCSSI_STO:
            begin
                if (!selected && bus_select_n)
                    state_d = dcssi_pkg::DCSSI_RUN;
            end
            default:
                state_d = dcssi_pkg::DCSSI_STO;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state_q <= dcssi_pkg::DCSSI_STO;
        else if (ce)
            state_q <= state_d;
    end

    // Stop one delay, loaded on selection and run down regardless
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ramp_cnt_q <= dcssi_pkg::TIMER_RESET;
        else if (ce)
        begin
            if (state_q != dcssi_pkg::DCSSI_RAMP)
                ramp_cnt_q <= cfg.ss1_delay_ms;
            else if (ms_tick && (ramp_cnt_q != '0))
                ramp_cnt_q <= ramp_cnt_q - 1'b1;
        end
    end

    // Registered outputs follow the next state of this drive only
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sto_q           <= 1'b1;
            ramp_q          <= 1'b0;
            brake_release_q <= 1'b0;
        end
        else if (ce)
        begin
            sto_q           <= state_d == dcssi_pkg::DCSSI_STO;
            ramp_q          <= state_d == dcssi_pkg::DCSSI_RAMP;
            brake_release_q <= !(cfg.sbc_enable && (state_d == dcssi_pkg::DCSSI_STO));
        end
    end

    // Response bounds reported for this configuration
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sto_worst_q <= dcssi_pkg::TIMER_RESET;
            bus_term_q  <= dcssi_pkg::TIMER_RESET;
        end
        else if (ce)
        begin
            sto_worst_q <= dcssi_pkg::MS_W'(dcssi_pkg::STO_MAX_MULT * cfg.safety_monitor_cycle
                           + cfg.io_sampling_time);
            bus_term_q  <= bus_term(cfg.isochronous_master, cfg.safety_bus_cycle);
        end
    end

    assign status.safe_torque_off      = sto_q;
    assign status.pulses_enabled       = !sto_q;
    assign status.fast_stop_ramp       = ramp_q;
    assign status.brake_release        = brake_release_q;
    assign status.cu_discrepancy_fault = cu_fault_q;
    assign status.mm_discrepancy_fault = mm_fault_q;
    assign status.stop_f               = cu_fault_q || mm_fault_q;
    assign status.sto_worst_ms         = sto_worst_q;
    assign status.bus_cycle_term       = bus_term_q;

    one_channel_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && (state_q == dcssi_pkg::DCSSI_RUN) && selected && (cfg.ss1_delay_ms == '0)) |=> sto_q)
        else $error("Single channel selection did not cancel pulses");

    deselect_run_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && (state_q == dcssi_pkg::DCSSI_STO) && cu_filt && mm_filt && bus_select_n) |=> !sto_q)
        else $error("Both channels high did not deselect");

    fault_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cu_fault_q) |-> $past(disagree) && ($past(disc_cnt_q) >= $past(cfg.cu_changeover_tolerance)))
        else $error("Control-unit fault without expired discrepancy");

    fault_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
        (mm_fault_q && (!fault_ack || disagree)) |=> mm_fault_q)
        else $error("Discrepancy fault cleared without ack");

    timer_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && !disagree) |=> (disc_cnt_q == '0))
        else $error("Discrepancy timer not cleared on agreement");

    and_units_a: assert property (@(posedge sys_clk) disable iff (rst)
        ((cfg.parallel_unit_count >= 4'h2) && !di[first_path_source[1]]) |-> !cu_raw)
        else $error("Second parallel unit input not in the AND");

    ramp_outputs_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == dcssi_pkg::DCSSI_RAMP) |-> ramp_q && !sto_q)
        else $error("Ramp state without ramp output");

    ramp_expiry_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && (state_q == dcssi_pkg::DCSSI_RAMP) && ms_tick && (ramp_cnt_q <= 16'h0001))
        |=> sto_q && (state_q == dcssi_pkg::DCSSI_STO))
        else $error("Stop one delay expiry did not enter torque off");

    brake_apply_a: assert property (@(posedge sys_clk) disable iff (rst)
        (sto_q && $past(cfg.sbc_enable) && $past(ce)) |-> !brake_release_q)
        else $error("Brake released during torque off");

    bus_select_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && !bus_select_n) |=> sto_q)
        else $error("Bus selection did not cancel pulses");
endmodule
`default_nettype wire

// >>> sim/dcssi_switch_model.sv
// Behavioural model of the outside switches driving both selection channels
`default_nettype none
module dcssi_switch_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] cu_sel,
    input  wire logic       mm_sel,
    input  wire logic [7:0] skew,
    output var logic [7:0]  di,
    output var logic        pulse_enable_terminal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_q;
    // First path contacts: select pulls low, open contact reads high
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            di <= 8'hff;
        else
            di <= ~cu_sel;
    end
    // Second path follows the command after a bounded changeover lag
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pulse_enable_terminal <= 1'b1;
            wait_q                <= 8'h00;
        end
        else if (pulse_enable_terminal == mm_sel)
        begin
            if (wait_q >= skew)
            begin
                pulse_enable_terminal <= ~mm_sel;
                wait_q                <= 8'h00;
            end
            else
                wait_q <= wait_q + 8'h01;
        end
        else
            wait_q <= 8'h00;
    end
endmodule
`default_nettype wire

// >>> sim/dcssi_safe_stop_test.sv
// Self-checking testbench of the dual-channel safe stop input
`default_nettype none
module dcssi_safe_stop_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPM  = 10;
    localparam int FILT = 8;
    localparam int KSTO = 0;
    localparam int KRMP = 1;
    localparam int KFLT = 2;
    localparam int KBRK = 3;
    localparam int KPEN = 4;
    logic                                                  sys_clk = 1'b0;
    logic                                                  rst = 1'b1;
    logic [7:0]                                            di;
    logic [7:0]                                            cu_sel = 8'h00;
    logic                                                  mm_sel = 1'b0;
    logic [7:0]                                            skew = 8'h00;
    logic                                                  pulse_enable_terminal;
    logic                                                  bus_select_n = 1'b1;
    logic                                                  fault_ack = 1'b0;
    logic [dcssi_pkg::MAX_UNITS-1:0][dcssi_pkg::SRC_W-1:0] first_path_source = '0;
    dcssi_pkg::dcssi_cfg_s                                 cfg = '0;
    dcssi_pkg::dcssi_status_s                              status;
    int                                                    num_errors = 0;
    int                                                    cmp_count = 0;
    int                                                    cycles = 0;

    dcssi_safe_stop #(.CLKS_PER_MS(CPM), .FILTER_CYCLES(FILT)) uut (
        .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .di(di), .first_path_source(first_path_source),
        .pulse_enable_terminal(pulse_enable_terminal), .bus_select_n(bus_select_n),
        .fault_ack(fault_ack), .cfg(cfg), .status(status));
    dcssi_switch_model partner (
        .sys_clk(sys_clk), .rst(rst), .cu_sel(cu_sel), .mm_sel(mm_sel), .skew(skew), .di(di),
        .pulse_enable_terminal(pulse_enable_terminal));

    // Clock
    always #12.5 sys_clk = ~sys_clk;
    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            KSTO:    pick = status.safe_torque_off;
            KRMP:    pick = status.fast_stop_ramp;
            KFLT:    pick = status.stop_f;
            KBRK:    pick = status.brake_release;
            default: pick = status.pulses_enabled;
        endcase
    endfunction
    // Wait a bounded number of cycles for a status bit, then compare
    task automatic wait_for(input int k, input logic val, input int maxc, input string what);
        int n;
        n = 0;
        #1;
        while (pick(k) !== val && n < maxc)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check({15'h0000, pick(k)}, {15'h0000, val}, what);
    endtask
    // Status bit must keep its level for n cycles
    task automatic hold(input int k, input logic val, input int n, input string what);
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            if (pick(k) !== val)
                break;
        end
        check({15'h0000, pick(k)}, {15'h0000, val}, what);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic sel_both(input logic [7:0] cu, input logic mm);
        @(posedge sys_clk);
        cu_sel <= cu;
        mm_sel <= mm;
    endtask
    // Fault acknowledge high for two edges
    task automatic ack_pulse();
        @(posedge sys_clk);
        fault_ack <= 1'b1;
        step(2);
        fault_ack <= 1'b0;
    endtask

    // Both channels selected with a small lag on the terminal
    task automatic t_both();
        skew <= 8'h04;
        sel_both(8'h01, 1'b1);
        hold(KSTO, 1'b0, FILT - 1, "early torque off");
        wait_for(KSTO, 1'b1, 10, "torque off on both");
        check({15'h0000, status.pulses_enabled}, 16'h0000, "pulses on");
        check({15'h0000, status.brake_release}, 16'h0000, "brake released");
        hold(KFLT, 1'b0, 40, "fault within tolerance");
        sel_both(8'h00, 1'b0);
        wait_for(KSTO, 1'b0, 16, "deselect");
        check({15'h0000, status.brake_release}, 16'h0001, "brake held");
        skew <= 8'h00;
    endtask
    // One channel alone: pulses go at once, fault after tolerance
    task automatic t_single(input logic on_cu);
        sel_both(on_cu ? 8'h01 : 8'h00, ~on_cu);
        wait_for(KSTO, 1'b1, FILT + 6, "single channel");
        check({15'h0000, status.stop_f}, 16'h0000, "fault too early");
        wait_for(KFLT, 1'b1, 40, "discrepancy");
        check({14'h0000, status.cu_discrepancy_fault, status.mm_discrepancy_fault}, 16'h0003, "unit faults");
        ack_pulse();
        hold(KFLT, 1'b1, 2, "ack while disagreeing");
        sel_both(8'h00, 1'b0);
        wait_for(KSTO, 1'b0, FILT + 6, "release");
        check({15'h0000, status.stop_f}, 16'h0001, "fault not sticky");
        ack_pulse();
        wait_for(KFLT, 1'b0, 3, "fault ack");
    endtask
    // Short dark pulse on both channels
    task automatic t_pulse();
        sel_both(8'h01, 1'b1);
        step(FILT - 1);
        cu_sel <= 8'h00;
        mm_sel <= 1'b0;
        hold(KSTO, 1'b0, 3 * FILT, "test pulse selected");
    endtask
    // Three parallel units, sources on inputs 2, 5 and 7
    task automatic t_and();
        @(posedge sys_clk);
        cfg.parallel_unit_count <= 4'h3;
        first_path_source[0]    <= 3'h2;
        first_path_source[1]    <= 3'h5;
        first_path_source[2]    <= 3'h7;
        sel_both(8'h01, 1'b0);
        hold(KSTO, 1'b0, 3 * FILT, "unused input");
        sel_both(8'h20, 1'b1);
        wait_for(KSTO, 1'b1, FILT + 6, "second unit source");
        sel_both(8'h00, 1'b0);
        wait_for(KSTO, 1'b0, FILT + 6, "second unit release");
        sel_both(8'h80, 1'b1);
        wait_for(KSTO, 1'b1, FILT + 6, "and of sources");
        check({15'h0000, status.stop_f}, 16'h0000, "and fault");
        sel_both(8'h00, 1'b0);
        wait_for(KSTO, 1'b0, FILT + 6, "and release");
        @(posedge sys_clk);
        first_path_source       <= '0;
        cfg.parallel_unit_count <= 4'h1;
    endtask
    // Stop one, deselected during the delay
    task automatic t_ss1();
        @(posedge sys_clk);
        cfg.ss1_delay_ms <= 16'h0003;
        sel_both(8'h01, 1'b1);
        wait_for(KRMP, 1'b1, FILT + 6, "ramp start");
        check({15'h0000, status.safe_torque_off}, 16'h0000, "torque off before delay");
        sel_both(8'h00, 1'b0);
        wait_for(KSTO, 1'b1, 50, "torque off after delay");
        wait_for(KSTO, 1'b0, 20, "stop one release");
        @(posedge sys_clk);
        cfg.ss1_delay_ms <= 16'h0000;
        step(FILT);
    endtask
    // Safety bus selection
    task automatic t_bus();
        @(posedge sys_clk);
        bus_select_n <= 1'b0;
        wait_for(KSTO, 1'b1, 3, "bus torque off");
        @(posedge sys_clk);
        bus_select_n <= 1'b1;
        wait_for(KSTO, 1'b0, 4, "bus release");
    endtask
    // Reported response bounds and bus term
    task automatic t_status();
        @(posedge sys_clk);
        cfg.safety_monitor_cycle <= 16'h0004;
        cfg.io_sampling_time     <= 16'h0004;
        cfg.safety_bus_cycle     <= 16'h0006;
        step(3);
        #1;
        check(status.sto_worst_ms, 16'h0014, "worst case");
        check(status.bus_cycle_term, 16'h0001, "bus term");
        @(posedge sys_clk);
        cfg.isochronous_master <= 1'b1;
        step(3);
        #1;
        check(status.bus_cycle_term, 16'h0006, "iso bus term");
    endtask

    // Main sequence
    initial
    begin
        cfg.cu_changeover_tolerance = 16'h0002;
        cfg.mm_changeover_tolerance = 16'h0002;
        cfg.sbc_enable              = 1'b1;
        cfg.parallel_unit_count     = 4'h1;
        step(10);
        #1;
        check({15'h0000, status.safe_torque_off}, 16'h0001, "reset torque off");
        check({15'h0000, status.pulses_enabled}, 16'h0000, "reset pulses");
        @(posedge sys_clk);
        rst <= 1'b0;
        wait_for(KSTO, 1'b0, 6, "start up");
        t_both();
        t_single(1'b1);
        t_single(1'b0);
        t_pulse();
        t_and();
        t_ss1();
        t_bus();
        t_status();
        finish_test();
    end
endmodule
`default_nettype wire
